// File: hdl/tbz_timer.sv
// 16-bit free-running compare timer with buzzer output and pin gating.
// Assumes a byte bus on sys_clk; clock status inputs come from the
// clock generator on the same clock; pins arrive asynchronously.
//
// Notes on behaviour
// R01 - Buzzer wave divides the selected count clock
// R02 - Codes 0..7 divide by 2^4,5,8..13
// R03 - Buzzer source is the selected count clock
// R04 - Buzzer drives only while enable bit0 set
// R05 - Pin shows wave only in output, latch 0
// R06 - Capture dead while main oscillator stopped
// R07 - Readout undefined when CPU slower than count
// R08 - Main count clock needs high-speed CPU for readout
// R09 - Sub clock, buzzer off: halts without main
// R10 - Sub clock, buzzer on: runs, capture unreliable
// R11 - Software masks irq, clears toggle before rewrite
// R12 - Rewrite timing may double or shorten intervals
// R13 - Byte rewrite: high first, wait half period
// R14 - Irq held half period; late enable inverts
// R15 - Word rewrite: wait one count period first
// R16 - Compare high byte above low byte
// R17 - Match raises irq, counter keeps running
// R18 - Buzzer is prescaler chain with selectable tap
`timescale 1ns/10ps
module tbz_timer
	import tbz_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] bus_addr,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	input  wire logic [7:0]  bus_wdata,
	output logic      [7:0]  bus_rdata,
	input  wire logic        main_osc_stopped,
	input  wire logic        cpu_on_sub_clk,
	input  wire logic        cpu_high_speed,
	input  wire logic        sub_clk_pin,
	input  wire logic        capture_pin,
	input  wire logic        buzzer_pin_dir,
	input  wire logic        buzzer_pin_latch,
	output logic             buzzer_pin_out,
	output logic             buzzer_pin_oe,
	output logic             compare_irq,
	output logic             toggle_out,
	output logic             readout_valid
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [TBZ_PRE_W-1:0] pre;
		logic                 sub_s1;
		logic                 sub_s2;
		logic                 sub_d;
		logic                 cap_s1;
		logic                 cap_s2;
		logic                 cap_d;
		logic [15:0]          free_run_counter;
		logic [15:0]          compare_value_word;
		logic [15:0]          capture_word;
		logic [7:0]           read_buf_hi;
		tbz_clksel_t          count_clk_sel;
		logic                 toggle_output_enable;
		logic [2:0]           buzzer_div_sel;
		logic                 buzzer_out_enable;
		logic                 timer_irq_flag;
		logic                 irq;
		logic [TBZ_PRE_W-1:0] irq_left;
		logic                 irq_wait_fall;
		logic                 tog;
		logic                 rdv;
		logic [7:0]           rdata;
		logic                 pin_out;
		logic                 pin_oe;
	} tbz_state_t;

	tbz_state_t st_reg;
	tbz_state_t st_next;

	logic       main_tick;
	logic       sub_rise;
	logic       sub_fall;
	logic       count_tick;
	logic       match;
	logic       capture_ok;
	logic       bz_wave;
	logic       wr_mode;
	logic [6:0] half_cycles;

	function automatic logic tbz_hit(input logic [15:0] a, input logic [15:0] ref_a);
		tbz_hit = (a == ref_a);
	endfunction

	// ---------------------------------------------------------------
	// Count clock generation
	// ---------------------------------------------------------------
	always_comb
	begin
		sub_rise = st_reg.sub_s2 && !st_reg.sub_d;
		sub_fall = !st_reg.sub_s2 && st_reg.sub_d;
		main_tick = 1'b0;
		half_cycles = TBZ_HALF4;
		unique case (st_reg.count_clk_sel)
			TBZ_CLK_DIV4:
			begin
				main_tick = (st_reg.pre & TBZ_PRE_MASK4) == TBZ_PRE_MASK4;
				half_cycles = TBZ_HALF4;
			end
			TBZ_CLK_DIV64:
			begin
				main_tick = (st_reg.pre & TBZ_PRE_MASK64) == TBZ_PRE_MASK64;
				half_cycles = TBZ_HALF64;
			end
			TBZ_CLK_DIV128:
			begin
				main_tick = st_reg.pre == TBZ_PRE_MASK128;
				half_cycles = TBZ_HALF128;
			end
			TBZ_CLK_SUB:
			begin
				main_tick = 1'b0;
				half_cycles = TBZ_HALF4;
			end
		endcase
		// Sub clock only reaches the counter through the main-clock
		// resynchroniser unless the buzzer bypass is selected
		if (st_reg.count_clk_sel == TBZ_CLK_SUB)
			count_tick = sub_rise && (!main_osc_stopped || st_reg.buzzer_out_enable); // see R09 see R10
		else
			count_tick = main_tick && !main_osc_stopped; // see R03
		match = count_tick && (st_reg.free_run_counter == st_reg.compare_value_word);
		capture_ok = !main_osc_stopped && // see R06
			!(st_reg.count_clk_sel == TBZ_CLK_SUB && st_reg.buzzer_out_enable); // see R10
		wr_mode = bus_wr && tbz_hit(bus_addr, TBZ_ADDR_MODE);
	end

	tbz_buzzer_div #(
		.CNT_W    (TBZ_BZ_CNT_W)
	) u_bz (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.src_tick (count_tick), // see R01 see R03
		.div_sel  (st_reg.buzzer_div_sel),
		.wave     (bz_wave)
	);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		st_next.pre = st_reg.pre + 1'b1;
		// Only the second flop of each synchroniser and its delayed copy feed logic
		st_next.sub_s1 = sub_clk_pin;
		st_next.sub_s2 = st_reg.sub_s1;
		st_next.sub_d = st_reg.sub_s2;
		st_next.cap_s1 = capture_pin;
		st_next.cap_s2 = st_reg.cap_s1;
		st_next.cap_d = st_reg.cap_s2;

		// Counter never clears on a match
		if (count_tick)
			st_next.free_run_counter = st_reg.free_run_counter + 1'b1; // see R17

		if (st_reg.cap_s2 && !st_reg.cap_d && capture_ok)
			st_next.capture_word = st_reg.free_run_counter; // see R06

		// Interrupt line stays high for half a count-clock period
		if (st_reg.irq)
		begin
			if (st_reg.irq_wait_fall)
			begin
				if (sub_fall)
					st_next.irq = 1'b0; // see R14
			end
			else if (st_reg.irq_left <= 7'h01)
				st_next.irq = 1'b0; // see R14
			else
				st_next.irq_left = st_reg.irq_left - 1'b1;
		end
		if (match)
		begin
			st_next.irq = 1'b1; // see R17
			st_next.irq_left = half_cycles;
			st_next.irq_wait_fall = st_reg.count_clk_sel == TBZ_CLK_SUB;
			if (st_reg.toggle_output_enable)
				st_next.tog = !st_reg.tog;
		end

		// Readout health: CPU must not be slower than the count clock
		if (st_reg.count_clk_sel == TBZ_CLK_SUB)
			st_next.rdv = !st_reg.buzzer_out_enable && !main_osc_stopped; // see R07 see R10
		else
			st_next.rdv = !cpu_on_sub_clk && cpu_high_speed && !main_osc_stopped; // see R08

		// Register writes
		if (bus_wr)
		begin
			if (tbz_hit(bus_addr, TBZ_ADDR_CMP_LO))
				st_next.compare_value_word[7:0] = bus_wdata; // see R16
			if (tbz_hit(bus_addr, TBZ_ADDR_CMP_HI))
				st_next.compare_value_word[15:8] = bus_wdata; // see R16
			if (tbz_hit(bus_addr, TBZ_ADDR_STATUS) && bus_wdata[TBZ_STAT_FLAG_BIT])
				st_next.timer_irq_flag = 1'b0;
			if (tbz_hit(bus_addr, TBZ_ADDR_BUZZER))
			begin
				st_next.buzzer_out_enable = bus_wdata[TBZ_BZ_EN_BIT]; // see R04
				st_next.buzzer_div_sel = bus_wdata[TBZ_BZ_DIV_LO +: 3]; // see R02
			end
		end
		if (wr_mode)
		begin
			st_next.count_clk_sel = tbz_clksel_t'(bus_wdata[TBZ_MODE_SEL_LO +: 2]);
			st_next.toggle_output_enable = bus_wdata[TBZ_MODE_TOC_BIT];
			// Enabling toggle while the line is still high inverts the output
			if (bus_wdata[TBZ_MODE_TOC_BIT] && !st_reg.toggle_output_enable && st_reg.irq)
				st_next.tog = !st_reg.tog; // see R14 see R12
		end
		// A match in the clearing cycle keeps the flag set
		if (match)
			st_next.timer_irq_flag = 1'b1; // see R17

		// Register reads: low counter byte freezes the high byte
		st_next.rdata = 8'h00;
		if (bus_rd)
		begin
			unique case (1'b1)
				tbz_hit(bus_addr, TBZ_ADDR_CNT_LO):
				begin
					st_next.rdata = st_reg.free_run_counter[7:0];
					st_next.read_buf_hi = st_reg.free_run_counter[15:8];
				end
				tbz_hit(bus_addr, TBZ_ADDR_CNT_HI): st_next.rdata = st_reg.read_buf_hi;
				tbz_hit(bus_addr, TBZ_ADDR_CAP_LO): st_next.rdata = st_reg.capture_word[7:0];
				tbz_hit(bus_addr, TBZ_ADDR_CAP_HI): st_next.rdata = st_reg.capture_word[15:8];
				tbz_hit(bus_addr, TBZ_ADDR_CMP_LO):
					st_next.rdata = st_reg.compare_value_word[7:0];
				tbz_hit(bus_addr, TBZ_ADDR_CMP_HI):
					st_next.rdata = st_reg.compare_value_word[15:8];
				tbz_hit(bus_addr, TBZ_ADDR_MODE):
					st_next.rdata = {2'h0, st_reg.count_clk_sel,
						st_reg.toggle_output_enable, 3'h0};
				tbz_hit(bus_addr, TBZ_ADDR_STATUS):
					st_next.rdata = {5'h00, capture_ok, st_reg.rdv, st_reg.timer_irq_flag};
				tbz_hit(bus_addr, TBZ_ADDR_BUZZER):
					st_next.rdata = {4'h0, st_reg.buzzer_div_sel, st_reg.buzzer_out_enable};
				default: st_next.rdata = 8'h00;
			endcase
		end

		// Shared pin: latch high overrides, input mode releases the pin
		st_next.pin_oe = !buzzer_pin_dir; // see R05
		st_next.pin_out = !buzzer_pin_dir &&
			(buzzer_pin_latch || (st_reg.buzzer_out_enable && bz_wave)); // see R04 see R05
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= '0;
			st_reg.free_run_counter <= TBZ_CNT_RST;
			st_reg.compare_value_word <= TBZ_CMP_RST;
			st_reg.count_clk_sel <= tbz_clksel_t'(TBZ_SEL_RST);
			st_reg.buzzer_div_sel <= TBZ_DIV_RST;
		end
		else
			st_reg <= st_next;
	end

	assign bus_rdata = st_reg.rdata;
	assign buzzer_pin_out = st_reg.pin_out;
	assign buzzer_pin_oe = st_reg.pin_oe;
	assign compare_irq = st_reg.irq;
	assign toggle_out = st_reg.tog;
	assign readout_valid = st_reg.rdv;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking tbz_cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence tbz_fast_match;
		match && st_reg.count_clk_sel == TBZ_CLK_DIV4;
	endsequence
	sequence tbz_half_hold;
		compare_irq [*2] ##1 !compare_irq;
	endsequence

	AST_MATCH_IRQ: assert property (match |=> compare_irq && st_reg.timer_irq_flag) // see R17
		else $error("match did not raise the interrupt");
	AST_NO_CLEAR: assert property (match |=>
		st_reg.free_run_counter == $past(st_reg.free_run_counter) + 16'h0001) // see R17
		else $error("counter did not keep counting on match");
	AST_HALF_HOLD: assert property (tbz_fast_match |=> tbz_half_hold) // see R14
		else $error("interrupt line not held two cycles");
	AST_BZ_OFF: assert property ((!st_reg.buzzer_out_enable && !buzzer_pin_dir
		&& !buzzer_pin_latch) |=> !buzzer_pin_out) // see R04
		else $error("buzzer drove pin while disabled");
	AST_LATCH_HIGH: assert property ((!buzzer_pin_dir && buzzer_pin_latch)
		|=> buzzer_pin_out && buzzer_pin_oe) // see R05
		else $error("latch one did not hold pin high");
	AST_CAP_STOP: assert property (main_osc_stopped |=> $stable(st_reg.capture_word)) // see R06
		else $error("capture changed with main oscillator stopped");
	AST_SUB_HALT: assert property ((st_reg.count_clk_sel == TBZ_CLK_SUB
		&& !st_reg.buzzer_out_enable && main_osc_stopped) |=> $stable(st_reg.free_run_counter)) // see R09
		else $error("counter ran without main oscillator");
	AST_RD_VALID: assert property ((st_reg.count_clk_sel != TBZ_CLK_SUB && !cpu_high_speed)
		|=> !readout_valid) // see R08
		else $error("readout flagged valid at low CPU speed");
	AST_CMP_HI: assert property ((bus_wr && bus_addr == TBZ_ADDR_CMP_HI)
		|=> st_reg.compare_value_word[15:8] == $past(bus_wdata)) // see R16
		else $error("compare high byte not written");

endmodule

// File: hdl/tbz_pkg.sv
// Constants shared by the compare timer and its buzzer prescaler.
// Assumes a byte-wide CPU data bus with 16-bit addresses.
package tbz_pkg;

	// -------------------------------------------------------------
	// Byte addresses
	// -------------------------------------------------------------
	localparam logic [15:0] TBZ_ADDR_CNT_LO  = 16'hff12;
	localparam logic [15:0] TBZ_ADDR_CNT_HI  = 16'hff13;
	localparam logic [15:0] TBZ_ADDR_CAP_LO  = 16'hff14;
	localparam logic [15:0] TBZ_ADDR_CAP_HI  = 16'hff15;
	localparam logic [15:0] TBZ_ADDR_CMP_LO  = 16'hff16;
	localparam logic [15:0] TBZ_ADDR_CMP_HI  = 16'hff17;
	localparam logic [15:0] TBZ_ADDR_MODE    = 16'hff18;
	localparam logic [15:0] TBZ_ADDR_STATUS  = 16'hff19;
	localparam logic [15:0] TBZ_ADDR_BUZZER  = 16'hff1a;

	// -------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------
	localparam int TBZ_MODE_SEL_LO   = 4;
	localparam int TBZ_MODE_TOC_BIT  = 3;
	localparam int TBZ_STAT_FLAG_BIT = 0;
	localparam int TBZ_STAT_RDV_BIT  = 1;
	localparam int TBZ_STAT_CAP_BIT  = 2;
	localparam int TBZ_BZ_EN_BIT     = 0;
	localparam int TBZ_BZ_DIV_LO     = 1;

	// -------------------------------------------------------------
	// Reset values
	// -------------------------------------------------------------
	localparam logic [15:0] TBZ_CMP_RST  = 16'hffff;
	localparam logic [15:0] TBZ_CNT_RST  = 16'h0000;
	localparam logic [1:0]  TBZ_SEL_RST  = 2'h0;
	localparam logic [2:0]  TBZ_DIV_RST  = 3'h0;

	// -------------------------------------------------------------
	// Count clock selection and timing
	// -------------------------------------------------------------
	typedef enum logic [1:0] {
		TBZ_CLK_DIV4,
		TBZ_CLK_DIV64,
		TBZ_CLK_DIV128,
		TBZ_CLK_SUB
	} tbz_clksel_t;

	localparam int          TBZ_PRE_W        = 7;
	localparam logic [6:0]  TBZ_PRE_MASK4    = 7'h03;
	localparam logic [6:0]  TBZ_PRE_MASK64   = 7'h3f;
	localparam logic [6:0]  TBZ_PRE_MASK128  = 7'h7f;
	// Half a count-clock period in system clocks, per main-clock source
	localparam logic [6:0]  TBZ_HALF4        = 7'h02;
	localparam logic [6:0]  TBZ_HALF64       = 7'h20;
	localparam logic [6:0]  TBZ_HALF128      = 7'h40;
	localparam int          TBZ_BZ_CNT_W     = 13;

endpackage

// File: hdl/tbz_buzzer_div.sv
// Buzzer prescaler: free-running chain on the selected count clock.
// Assumes src_tick is a one-cycle pulse on sys_clk per source edge.
`timescale 1ns/10ps
module tbz_buzzer_div
	import tbz_pkg::*;
#(
	parameter int CNT_W = TBZ_BZ_CNT_W
)
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       src_tick,
	input  wire logic [2:0] div_sel,
	output logic            wave
);

	typedef struct packed {
		logic [CNT_W-1:0] chain;
		logic             wave;
	} tbz_bzst_t;

	tbz_bzst_t st_reg;
	tbz_bzst_t st_next;

	// Tap bit that toggles every 2^(n-1) ticks gives fcl/2^n
	function automatic logic [3:0] tbz_tap(input logic [2:0] sel);
		unique case (sel)
			3'h0:    tbz_tap = 4'h3;
			3'h1:    tbz_tap = 4'h4;
			3'h2:    tbz_tap = 4'h7;
			3'h3:    tbz_tap = 4'h8;
			3'h4:    tbz_tap = 4'h9;
			3'h5:    tbz_tap = 4'ha;
			3'h6:    tbz_tap = 4'hb;
			3'h7:    tbz_tap = 4'hc;
		endcase
	endfunction

	always_comb
	begin
		st_next = st_reg;
		if (src_tick)
			st_next.chain = st_reg.chain + 1'b1; // see R18
		st_next.wave = st_reg.chain[tbz_tap(div_sel)]; // see R01 see R02
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign wave = st_reg.wave;

	AST_BZ_TAP0: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(div_sel == 3'h0 && $stable(div_sel)) |-> wave == $past(st_reg.chain[3])) // see R02
		else $error("buzzer tap for code 0 wrong");

endmodule

// File: test/tbz_pin_load.sv
// Load on the buzzer pin: it resolves the pin level and times the gap between edges.
// Assumes a pull-up that holds the pin high while the timer does not drive it.
`timescale 1ns/10ps
module tbz_pin_load
(
	input  wire logic sys_clk,
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output logic      pin_level,
	output int        edge_cnt,
	output int        half_len
);
	int   run  = 0;
	int   cnt  = 0;
	int   half = 0;
	logic last = 1'b1;

	// -------------------------------------------------------------
	// Pin resolution and edge timing
	// -------------------------------------------------------------
	// An undriven pin floats up to the pull-up level
	assign pin_level = pin_oe ? pin_out : 1'b1;
	assign edge_cnt  = cnt;
	assign half_len  = half;

	always @(posedge sys_clk)
	begin
		last <= pin_level;
		run  <= (pin_level !== last) ? 1 : run + 1;
		if (pin_level !== last)
		begin
			cnt  <= cnt + 1;
			half <= run;
		end
	end
endmodule

// File: test/timer16_buzzer_compare_rewrite_tb.sv
// Bench for the compare timer: compare bytes, readout gating, capture, match, buzzer taps.
// Assumes the pin load model beside it and a 25 MHz sys_clk.
`timescale 1ns/10ps
module timer16_buzzer_compare_rewrite_tb import tbz_pkg::*;;
	logic        sys_clk, rst_n, bus_wr, bus_rd;
	logic [15:0] bus_addr;
	logic [7:0]  bus_wdata, bus_rdata;
	logic        main_osc_stopped, cpu_on_sub_clk, cpu_high_speed, sub_clk_pin;
	logic        capture_pin, buzzer_pin_dir, buzzer_pin_latch, buzzer_pin_out;
	logic        buzzer_pin_oe, compare_irq, toggle_out, readout_valid, pin_level, sub_on;
	int          edge_cnt, half_len, n_errors, num_checks, cycles;
	int          pw[8] = '{4, 5, 8, 9, 10, 11, 12, 13};

	tbz_timer dut
	(
		.sys_clk, .rst_n, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata,
		.main_osc_stopped, .cpu_on_sub_clk, .cpu_high_speed, .sub_clk_pin,
		.capture_pin, .buzzer_pin_dir, .buzzer_pin_latch, .buzzer_pin_out,
		.buzzer_pin_oe, .compare_irq, .toggle_out, .readout_valid
	);
	tbz_pin_load load
	(
		.sys_clk, .pin_out(buzzer_pin_out), .pin_oe(buzzer_pin_oe), .pin_level,
		.edge_cnt, .half_len
	);

	// -------------------------------------------------------------
	// Clocks and watchdog
	// -------------------------------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Subsystem oscillator, 12 system clocks a period so tap widths are exact
	initial
	begin
		sub_clk_pin = 1'b0;
		forever
		begin
			repeat (6) @(posedge sys_clk);
			#1 sub_clk_pin = sub_on & ~sub_clk_pin;
		end
	end

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			n_errors++;
			complete_run();
		end
	end

	// -------------------------------------------------------------
	// Shared tasks
	// -------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	// A spare cycle after each strobe keeps two accesses from meeting in one step
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		cyc(1);
		bus_wr = 1'b0;
		cyc(1);
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		bus_addr = a;
		bus_rd = 1'b1;
		cyc(1);
		bus_rd = 1'b0;
		d = bus_rdata;
		cyc(1);
	endtask

	task automatic rd16(input logic [15:0] a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 16'h0001, v[15:8]);
	endtask

	task automatic wait_edges(input int n);
		int e;
		e = edge_cnt;
		for (int i = 0; i < 40000 && edge_cnt < e + n; i++)
			cyc(1);
		chk("buzzer edges", edge_cnt >= e + n, 1'b1);
	endtask

	task automatic wait_irq();
		for (int i = 0; i < 1000 && compare_irq !== 1'b1; i++)
			cyc(1);
		chk("irq seen", compare_irq, 1'b1);
	endtask

	task automatic cap_read(output logic [15:0] v);
		capture_pin = 1'b1;
		cyc(8);
		capture_pin = 1'b0;
		cyc(4);
		rd16(TBZ_ADDR_CAP_LO, v);
	endtask

	// -------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------
	task automatic t_cmp_bytes();
		logic [7:0] d;
		rd(TBZ_ADDR_CMP_HI, d);
		chk("cmp hi reset", d, TBZ_CMP_RST[15:8]);
		wr(TBZ_ADDR_CMP_HI, 8'h12);
		wr(TBZ_ADDR_CMP_LO, 8'h34);
		rd(TBZ_ADDR_CMP_HI, d);
		chk("cmp hi", d, 8'h12);
		rd(TBZ_ADDR_CMP_LO, d);
		chk("cmp lo", d, 8'h34);
		rd(16'hff30, d);
		chk("unmapped", d, 8'h00);
		$display("test cmp_bytes done");
	endtask

	task automatic t_readout();
		logic [3:0] tc[4] = '{4'b0101, 4'b0000, 4'b1100, 4'b0110};
		logic [7:0] d;
		wr(TBZ_ADDR_MODE, 8'h00);
		foreach (tc[i])
		begin
			{cpu_on_sub_clk, cpu_high_speed, main_osc_stopped} = tc[i][3:1];
			cyc(3);
			chk("readout valid", readout_valid, tc[i][0]);
			rd(TBZ_ADDR_STATUS, d);
			chk("status valid", d[1], tc[i][0]);
		end
		{cpu_on_sub_clk, cpu_high_speed, main_osc_stopped} = 3'b010;
		$display("test readout done");
	endtask

	task automatic t_capture();
		logic [15:0] a, b;
		cap_read(a);
		cyc(20);
		main_osc_stopped = 1'b1;
		cyc(20);
		cap_read(b);
		chk("capture stopped", b, a);
		main_osc_stopped = 1'b0;
		cyc(50);
		cap_read(b);
		chk("capture runs", b !== a, 1'b1);
		$display("test capture done");
	endtask

	task automatic t_match();
		logic [15:0] c, m;
		logic [7:0]  d;
		logic        t;
		int          w;
		wr(TBZ_ADDR_MODE, 8'h10);
		rd16(TBZ_ADDR_CNT_LO, c);
		m = c + 16'h0006;
		wr(TBZ_ADDR_CMP_HI, m[15:8]);
		wr(TBZ_ADDR_CMP_LO, m[7:0]);
		wait_irq();
		t = toggle_out;
		wr(TBZ_ADDR_MODE, 8'h18);
		cyc(2);
		chk("late toggle", toggle_out, !t);
		wr(TBZ_ADDR_MODE, 8'h10);
		m = m + 16'h0004;
		wr(TBZ_ADDR_CMP_HI, m[15:8]);
		wr(TBZ_ADDR_CMP_LO, m[7:0]);
		wr(TBZ_ADDR_STATUS, 8'h01);
		rd(TBZ_ADDR_STATUS, d);
		chk("flag cleared", d[0], 1'b0);
		// Re-enabling toggle before the line drops would invert the output
		cyc(20);
		wr(TBZ_ADDR_MODE, 8'h18);
		t = toggle_out;
		wait_irq();
		w = 0;
		while (compare_irq === 1'b1 && w < 200)
		begin
			w++;
			cyc(1);
		end
		chk("irq width", w, 32);
		chk("match toggle", toggle_out, !t);
		rd(TBZ_ADDR_STATUS, d);
		chk("flag set", d[0], 1'b1);
		rd16(TBZ_ADDR_CNT_LO, c);
		chk("no clear", c > m, 1'b1);
		// Fast count clock: word rewrite, wait one count period, then clear
		wr(TBZ_ADDR_MODE, 8'h00);
		rd16(TBZ_ADDR_CNT_LO, c);
		m = c + 16'h0010;
		wr(TBZ_ADDR_CMP_HI, m[15:8]);
		wr(TBZ_ADDR_CMP_LO, m[7:0]);
		cyc(5);
		wr(TBZ_ADDR_STATUS, 8'h01);
		wait_irq();
		w = 0;
		while (compare_irq === 1'b1 && w < 200)
		begin
			w++;
			cyc(1);
		end
		chk("fast irq width", w, 2);
		$display("test match done");
	endtask

	task automatic t_div_codes();
		wr(TBZ_ADDR_MODE, 8'h00);
		for (int k = 0; k < 8; k++)
		begin
			wr(TBZ_ADDR_BUZZER, {4'h0, k[2:0], 1'b1});
			cyc(4);
			wait_edges(2);
			chk("buzzer half", half_len, 1 << (pw[k] + 1));
		end
		$display("test div_codes done");
	endtask

	task automatic t_pin();
		int e;
		wr(TBZ_ADDR_BUZZER, 8'h00);
		cyc(3);
		e = edge_cnt;
		cyc(100);
		chk("pin off", pin_level, 1'b0);
		chk("pin edges off", edge_cnt, e);
		buzzer_pin_latch = 1'b1;
		wr(TBZ_ADDR_BUZZER, 8'h01);
		cyc(3);
		e = edge_cnt;
		cyc(100);
		chk("pin latch", pin_level, 1'b1);
		chk("pin edges latch", edge_cnt, e);
		buzzer_pin_latch = 1'b0;
		buzzer_pin_dir = 1'b1;
		cyc(3);
		chk("pin oe", buzzer_pin_oe, 1'b0);
		buzzer_pin_dir = 1'b0;
		cyc(4);
		wait_edges(2);
		chk("pin on", half_len, 32);
		$display("test pin done");
	endtask

	task automatic t_sub();
		logic [15:0] a, b;
		sub_on = 1'b1;
		wr(TBZ_ADDR_MODE, 8'h30);
		cyc(4);
		wait_edges(2);
		chk("sub half", half_len, 96);
		main_osc_stopped = 1'b1;
		cyc(4);
		wait_edges(2);
		chk("sub half stopped", half_len, 96);
		chk("readout sub buzzer", readout_valid, 1'b0);
		wr(TBZ_ADDR_BUZZER, 8'h00);
		rd16(TBZ_ADDR_CNT_LO, a);
		cyc(100);
		rd16(TBZ_ADDR_CNT_LO, b);
		chk("halted", b, a);
		main_osc_stopped = 1'b0;
		cyc(3);
		chk("readout sub", readout_valid, 1'b1);
		rd16(TBZ_ADDR_CNT_LO, a);
		cyc(100);
		rd16(TBZ_ADDR_CNT_LO, b);
		chk("sub counts", b !== a, 1'b1);
		$display("test sub done");
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// -------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------
	initial
	begin
		{rst_n, bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
		{main_osc_stopped, cpu_on_sub_clk, cpu_high_speed, capture_pin} = 4'h2;
		{buzzer_pin_dir, buzzer_pin_latch, sub_on} = 3'h0;
		{n_errors, num_checks, cycles} = '0;
		cyc(6);
		rst_n = 1'b1;
		cyc(1);
		t_cmp_bytes();
		t_readout();
		t_capture();
		t_match();
		t_div_codes();
		t_pin();
		t_sub();
		complete_run();
	end
endmodule
